/* File: design/eivs_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * external interrupt and vector select block.
 * Assumes an 8-bit register port addressed by a small byte offset.
 */
`ifndef EIVS_REGS_SVH
`define EIVS_REGS_SVH

// ==========================================================
// Register offsets
`define EIVS_OFS_CORE_CTRL     4'h0
`define EIVS_OFS_SENSE_CTRL    4'h1
`define EIVS_OFS_IRQ_MASK      4'h2
`define EIVS_OFS_IRQ_FLAGS     4'h3
`define EIVS_OFS_PC_CTRL       4'h4
`define EIVS_OFS_PC_FLAGS      4'h5
`define EIVS_OFS_PC_MASK0      4'h6
`define EIVS_OFS_PC_MASK1      4'h7
`define EIVS_OFS_PC_MASK2      4'h8
`define EIVS_OFS_PC_MASK3      4'h9
`define EIVS_OFS_STATUS        4'ha

// ==========================================================
// Field positions
`define EIVS_BIT_UNLOCK        0
`define EIVS_BIT_VSEL          1

// ==========================================================
// Sense encodings
`define EIVS_SENSE_LOW         2'h0
`define EIVS_SENSE_ANY         2'h1
`define EIVS_SENSE_FALL        2'h2
`define EIVS_SENSE_RISE        2'h3

// ==========================================================
// Reset values and timing
`define EIVS_RST_BYTE          8'h00
`define EIVS_UNLOCK_CYCLES     3'h4

`endif

/* File: design/eivs_pkg.sv */
/*
 * Types shared by the external interrupt and vector select block.
 * Assumes the constants header is included by each user.
 */
package eivs_pkg;

   // ==========================================================
   // Vector change sequencer states
   typedef enum logic [1:0] {
      EIVS_IDLE   = 2'b00,
      EIVS_OPEN   = 2'b01,
      EIVS_TRAIL  = 2'b10
   } eivs_vstate_t;

   // ==========================================================
   // Request numbering toward the core
   typedef logic [6:0] eivs_req_t;

endpackage

/* File: design/eivs_sync_if.sv */
/*
 * Interface carrying raw pins into the synchroniser and clean levels out.
 * Assumes a single system clock.
 */
`timescale 1ns/100ps

interface eivs_sync_if;
   logic [34:0] raw;
   logic [34:0] clean;

   modport src (output raw, input clean);
   modport syn (input raw, output clean);
endinterface // eivs_sync_if

/* File: design/eivs_sync.sv */
/*
 * Two-flop synchroniser for all asynchronous pin inputs.
 * Assumes pins are asynchronous to clk_sys.
 */
`timescale 1ns/100ps

module eivs_sync (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Pin lines
   eivs_sync_if.syn sif
);

   logic [34:0] meta_ff;
   logic [34:0] clean_ff;

   // ==========================================================
   // Two stages, first read only by second
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= 35'h7ffffffff;
         clean_ff <= 35'h7ffffffff;
      end else begin
         meta_ff <= sif.raw;
         clean_ff <= meta_ff; // RULE24
      end
   end

   assign sif.clean = clean_ff;

endmodule // eivs_sync

/* File: design/eivs_edge.sv */
/*
 * Sense decoder for one dedicated interrupt input.
 * Assumes a synchronised pin level and its previous value.
 */
`timescale 1ns/100ps
`include "eivs_regs.svh"

module eivs_edge (
   // Levels
   input wire logic cur,
   input wire logic prev,
   // Mode
   input wire logic [1:0] sense,
   // Result
   output logic edge_hit,
   output logic low_req
);

   // ==========================================================
   // Decode the two-bit sense field
   always_comb begin
      edge_hit = 1'b0;
      low_req = 1'b0;
      unique case (sense)
         `EIVS_SENSE_LOW: low_req = ~cur; // RULE11
         `EIVS_SENSE_ANY: edge_hit = cur ^ prev; // RULE10
         `EIVS_SENSE_FALL: edge_hit = prev & ~cur;
         `EIVS_SENSE_RISE: edge_hit = ~prev & cur;
      endcase
   end

endmodule // eivs_edge

/* File: design/eivs_top.sv */
/*
 * External interrupt front end: three dedicated inputs with sense control,
 * 32 pin-change inputs in four groups, and the vector base select with its
 * timed unlock. Requests go to the core as levels; the core acknowledges
 * handler entry with a one-cycle pulse per request.
 * Assumes pins are asynchronous, register port and core on clk_sys.
 */
`timescale 1ns/100ps
`include "eivs_regs.svh"

// Summary of operation
// RULE1: Select bit 0 puts vectors at program start, 1 at boot section.
// RULE2: Software sets unlock, then writes select with unlock zero within four cycles.
// RULE3: Interrupts blocked from unlock set until after instruction following select write.
// RULE4: Automatic blocking never touches the global enable bit.
// RULE5: Unlock clears by hardware after four cycles or on select write.
// RULE6: Lock inputs suppress interrupts while executing from the other section.
// RULE7: Pins trigger interrupts even when driven as outputs.
// RULE8: Group request set when any enabled input in its byte toggles.
// RULE9: Pin events need no I/O clock and can signal wake in any sleep.
// RULE10: Sense field per input: low, any, falling, rising edge; bits 5:0.
// RULE11: Low-level mode keeps requesting while pin stays low.
// RULE12: Source holds low level until current instruction completes.
// RULE13: Low level gone before start-up ends wakes without an interrupt.
// RULE14: Sense control bits 7:6 read zero.
// RULE15: Dedicated interrupt enabled by mask bit and global enable; mask bits 2:0.
// RULE16: Event sets flag; handler entry or writing one clears it.
// RULE17: Flag held cleared while input in low-level mode.
// RULE18: Sleep with interrupt disabled gates the input buffer; may set flag.
// RULE19: Software masks, changes sense, clears flag, then re-enables.
// RULE20: Group 3 enable plus global enable requests group 3 vector on change.
// RULE21: Group enables 2,1,0 at pin-change control bits 2,1,0.
// RULE22: Group flag set by change, cleared by handler or writing one.
// RULE23: Each pin-change input has a mask bit resetting zero.
// RULE24: Asynchronous events synchronised before updating flags or requests.
module eivs_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Pins
   input wire logic [2:0] dedicated_irq_inputs,
   input wire logic [31:0] pin_change_inputs,
   // Core side
   input wire logic status_register_i,
   input wire logic sleep_active,
   input wire logic startup_done,
   input wire logic exec_in_boot,
   input wire logic application_lock_input,
   input wire logic boot_lock_input,
   input wire logic instr_done,
   input wire logic [6:0] irq_ack,
   output logic [6:0] irq_req,
   output logic vector_base_select,
   output logic irq_blocked,
   output logic wake_req
);

   // ==========================================================
   // Declarations
   eivs_sync_if sif();
   logic [7:0] core_control_ff;
   logic [5:0] ext_sense_control_ff;
   logic [2:0] ext_irq_mask_ff;
   logic [2:0] ext_irq_flags_ff;
   logic [3:0] pin_change_control_ff;
   logic [3:0] pc_flags_ff;
   logic [31:0] pc_mask_ff;
   logic [2:0] ded_prev_ff;
   logic [31:0] pc_prev_ff;
   logic [2:0] low_pend_ff;
   logic [2:0] cnt_ff;
   logic [2:0] nxt_cnt;
   logic [7:0] reg_rdata_ff;
   logic [6:0] irq_req_ff;
   logic vsel_ff;
   logic blocked_ff;
   logic wake_ff;
   eivs_pkg::eivs_vstate_t vstate_ff;
   eivs_pkg::eivs_vstate_t nxt_vstate;
   logic [2:0] ded_cur;
   logic [31:0] pc_cur;
   logic [2:0] ded_edge;
   logic [2:0] ded_low;
   logic [3:0] grp_hit;
   logic [31:0] pc_toggle;
   logic gate_open;
   logic lock_block;
   logic seq_block;
   logic wr_core;
   logic wr_flags;
   logic wr_pcflags;

   // ==========================================================
   // Dedicated input buffers: disabled in sleep when the input's interrupt is off
   always_comb begin
      sif.raw = {dedicated_irq_inputs, pin_change_inputs}; // RULE7
      for (int i = 0; i < 3; i++) begin
         if (sleep_active && !ext_irq_mask_ff[i]) begin
            sif.raw[32 + i] = 1'b0; // RULE18
         end
      end
   end

   eivs_sync u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .sif(sif)
   );

   assign ded_cur = sif.clean[34:32];
   assign pc_cur = sif.clean[31:0];

   // ==========================================================
   // Sense decoders, one per dedicated input
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sense
         eivs_edge u_edge (
            .cur(ded_cur[g]),
            .prev(ded_prev_ff[g]),
            .sense(ext_sense_control_ff[2*g +: 2]),
            .edge_hit(ded_edge[g]),
            .low_req(ded_low[g])
         );
      end
   endgenerate

   // Masked toggles grouped by byte
   assign pc_toggle = (pc_cur ^ pc_prev_ff) & pc_mask_ff; // RULE23
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         grp_hit[k] = |pc_toggle[8*k +: 8] & pin_change_control_ff[k]; // RULE8 RULE21
      end
   end

   // ==========================================================
   // Register strobes
   assign wr_core = reg_wr && (reg_addr == `EIVS_OFS_CORE_CTRL);
   assign wr_flags = reg_wr && (reg_addr == `EIVS_OFS_IRQ_FLAGS);
   assign wr_pcflags = reg_wr && (reg_addr == `EIVS_OFS_PC_FLAGS);

   // History of synchronised levels
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ded_prev_ff <= 3'h7;
         pc_prev_ff <= 32'hffffffff;
      end else begin
         ded_prev_ff <= ded_cur;
         pc_prev_ff <= pc_cur;
      end
   end

   // ==========================================================
   // Plain read/write configuration registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ext_sense_control_ff <= 6'h00;
         ext_irq_mask_ff <= 3'h0;
         pin_change_control_ff <= 4'h0;
         pc_mask_ff <= 32'h00000000; // RULE23
      end else if (reg_wr) begin
         unique case (reg_addr)
            `EIVS_OFS_SENSE_CTRL: ext_sense_control_ff <= reg_wdata[5:0]; // RULE10
            `EIVS_OFS_IRQ_MASK: ext_irq_mask_ff <= reg_wdata[2:0]; // RULE15
            `EIVS_OFS_PC_CTRL: pin_change_control_ff <= reg_wdata[3:0]; // RULE21
            `EIVS_OFS_PC_MASK0: pc_mask_ff[7:0] <= reg_wdata;
            `EIVS_OFS_PC_MASK1: pc_mask_ff[15:8] <= reg_wdata;
            `EIVS_OFS_PC_MASK2: pc_mask_ff[23:16] <= reg_wdata;
            `EIVS_OFS_PC_MASK3: pc_mask_ff[31:24] <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Dedicated input flags: set wins over clear
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ext_irq_flags_ff <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (ext_sense_control_ff[2*i +: 2] == `EIVS_SENSE_LOW) begin
               ext_irq_flags_ff[i] <= 1'b0; // RULE17
            end else if (ded_edge[i]) begin
               ext_irq_flags_ff[i] <= 1'b1; // RULE16
            end else if ((wr_flags && reg_wdata[i]) || irq_ack[i]) begin
               ext_irq_flags_ff[i] <= 1'b0; // RULE16
            end
         end
      end
   end

   // ==========================================================
   // Pin-change group flags: set wins over clear
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pc_flags_ff <= 4'h0;
      end else begin
         for (int k = 0; k < 4; k++) begin
            if (grp_hit[k]) begin
               pc_flags_ff[k] <= 1'b1; // RULE22
            end else if ((wr_pcflags && reg_wdata[k]) || irq_ack[3 + k]) begin
               pc_flags_ff[k] <= 1'b0; // RULE22
            end
         end
      end
   end

   // ==========================================================
   // Low level must still be present when start-up ends
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         low_pend_ff <= 3'h0;
      end else begin
         low_pend_ff <= ded_low & ext_irq_mask_ff & {3{startup_done}}; // RULE13
      end
   end

   // ==========================================================
   // Vector change sequencer
   always_comb begin
      nxt_vstate = vstate_ff;
      nxt_cnt = cnt_ff;
      unique case (vstate_ff)
         eivs_pkg::EIVS_IDLE: begin
            if (wr_core && reg_wdata[`EIVS_BIT_UNLOCK]) begin
               nxt_vstate = eivs_pkg::EIVS_OPEN; // RULE2
               nxt_cnt = `EIVS_UNLOCK_CYCLES - 3'h1;
            end
         end
         eivs_pkg::EIVS_OPEN: begin
            if (wr_core && !reg_wdata[`EIVS_BIT_UNLOCK]) begin
               nxt_vstate = eivs_pkg::EIVS_TRAIL; // RULE5
            end else if (cnt_ff == 3'h1) begin
               nxt_vstate = eivs_pkg::EIVS_IDLE; // RULE5
               nxt_cnt = 3'h0;
            end else begin
               nxt_cnt = cnt_ff - 3'h1;
            end
         end
         eivs_pkg::EIVS_TRAIL: begin
            if (instr_done) begin
               nxt_vstate = eivs_pkg::EIVS_IDLE; // RULE3
               nxt_cnt = 3'h0;
            end
         end
         default: nxt_vstate = eivs_pkg::EIVS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         vstate_ff <= eivs_pkg::EIVS_IDLE;
         cnt_ff <= 3'h0;
      end else begin
         vstate_ff <= nxt_vstate;
         cnt_ff <= nxt_cnt;
      end
   end

   // Select bit and readable core control image
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         vsel_ff <= 1'b0;
         core_control_ff <= `EIVS_RST_BYTE;
      end else begin
         if (vstate_ff == eivs_pkg::EIVS_OPEN && wr_core && !reg_wdata[`EIVS_BIT_UNLOCK]) begin
            vsel_ff <= reg_wdata[`EIVS_BIT_VSEL]; // RULE1 RULE2
         end
         core_control_ff <= {6'h00, 1'b0, nxt_vstate == eivs_pkg::EIVS_OPEN};
      end
   end

   // ==========================================================
   // Blocking: sequence and section locks, global enable untouched
   assign seq_block = (nxt_vstate != eivs_pkg::EIVS_IDLE); // RULE3 RULE4
   assign lock_block = (vsel_ff && application_lock_input && !exec_in_boot) ||
                       (!vsel_ff && boot_lock_input && exec_in_boot); // RULE6
   assign gate_open = status_register_i && !seq_block && !lock_block; // RULE15 RULE20

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_req_ff <= 7'h00;
         blocked_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         irq_req_ff[2:0] <= (ext_irq_flags_ff & ext_irq_mask_ff | low_pend_ff) & {3{gate_open}}; // RULE11
         irq_req_ff[6:3] <= pc_flags_ff & pin_change_control_ff & {4{gate_open}}; // RULE20
         blocked_ff <= seq_block;
         wake_ff <= |(ext_irq_flags_ff & ext_irq_mask_ff) | |(ded_low & ext_irq_mask_ff) |
                    |(pc_flags_ff & pin_change_control_ff); // RULE9
      end
   end

   // ==========================================================
   // Read data, one cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `EIVS_OFS_CORE_CTRL: reg_rdata_ff <= {6'h00, vsel_ff, core_control_ff[0]};
            `EIVS_OFS_SENSE_CTRL: reg_rdata_ff <= {2'h0, ext_sense_control_ff}; // RULE14
            `EIVS_OFS_IRQ_MASK: reg_rdata_ff <= {5'h00, ext_irq_mask_ff};
            `EIVS_OFS_IRQ_FLAGS: reg_rdata_ff <= {5'h00, ext_irq_flags_ff};
            `EIVS_OFS_PC_CTRL: reg_rdata_ff <= {4'h0, pin_change_control_ff};
            `EIVS_OFS_PC_FLAGS: reg_rdata_ff <= {4'h0, pc_flags_ff};
            `EIVS_OFS_PC_MASK0: reg_rdata_ff <= pc_mask_ff[7:0];
            `EIVS_OFS_PC_MASK1: reg_rdata_ff <= pc_mask_ff[15:8];
            `EIVS_OFS_PC_MASK2: reg_rdata_ff <= pc_mask_ff[23:16];
            `EIVS_OFS_PC_MASK3: reg_rdata_ff <= pc_mask_ff[31:24];
            `EIVS_OFS_STATUS: reg_rdata_ff <= {5'h00, blocked_ff, lock_block, wake_ff};
            default: reg_rdata_ff <= 8'h00;
         endcase
      end else begin
         reg_rdata_ff <= 8'h00;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata = reg_rdata_ff;
   assign irq_req = irq_req_ff;
   assign vector_base_select = vsel_ff;
   assign irq_blocked = blocked_ff;
   assign wake_req = wake_ff;

endmodule // eivs_top

/* File: dv/eivs_core_model.sv */
/*
 * Core-side partner: takes vectored requests and answers with handler entry.
 * Assumes each request stays a level until its flag clears.
 */
`timescale 1ns/100ps

module eivs_core_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Requests and acknowledges
   input wire logic [6:0] irq_req,
   output logic [6:0] irq_ack,
   // Knobs and tally
   input wire logic ack_en,
   input wire logic [3:0] ack_dly,
   output logic [7:0] ack_cnt
);
   logic [3:0] dly_ff;
   logic [1:0] hold_ff;
   logic [6:0] pick;

   // Lowest pending request wins
   assign pick = irq_req & (~irq_req + 7'h01);

   // Entry after a set delay, then a two-cycle hold before the next entry
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_ack <= 7'h00;
         dly_ff <= 4'h0;
         hold_ff <= 2'h0;
         ack_cnt <= 8'h00;
      end else if (irq_ack != 7'h00) begin
         irq_ack <= 7'h00;
         hold_ff <= 2'h2;
      end else if (hold_ff != 2'h0) begin
         hold_ff <= hold_ff - 2'h1;
      end else if (ack_en && pick != 7'h00 && dly_ff >= ack_dly) begin
         irq_ack <= pick;
         dly_ff <= 4'h0;
         ack_cnt <= ack_cnt + 8'h01;
      end else if (ack_en && pick != 7'h00) begin
         dly_ff <= dly_ff + 4'h1;
      end
   end
endmodule // eivs_core_model

/* File: dv/eivs_top_assertions.sv */
/*
 * Port checker for the external interrupt and vector select block.
 * Assumes one clock, bound onto eivs_top.
 */
`timescale 1ns/100ps
`include "eivs_regs.svh"

module eivs_chk (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Core side
   input wire logic status_register_i,
   input wire logic exec_in_boot,
   input wire logic application_lock_input,
   input wire logic [6:0] irq_req,
   input wire logic vector_base_select,
   input wire logic irq_blocked
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic app_lock;

   // Vectors in boot, application code running, lock set
   assign app_lock = vector_base_select && application_lock_input && !exec_in_boot;

   // ==========================================================
   // Assertions
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its slot");
   sense_rsvd_a: assert property ($past(reg_rd) && $past(reg_addr) == `EIVS_OFS_SENSE_CTRL |-> reg_rdata[7:6] == 2'h0)
      else $error("sense reserved bits not zero");
   gie_gate_a: assert property (!status_register_i && !$past(status_register_i) && !$past(status_register_i, 2)
      |-> irq_req == 7'h00)
      else $error("request without global enable");
   block_start_a: assert property (reg_wr && reg_addr == `EIVS_OFS_CORE_CTRL && reg_wdata == 8'h01 |=> irq_blocked)
      else $error("unlock did not block");
   block_mute_a: assert property (irq_blocked |-> irq_req == 7'h00)
      else $error("request while blocked");
   block_end_a: assert property ($rose(irq_blocked) && !reg_wr ##1 !reg_wr [*3] |-> ##[1:2] !irq_blocked)
      else $error("blocking outlived unlock window");
   vsel_write_a: assert property (vector_base_select != $past(vector_base_select) |-> $past(reg_wr)
      && $past(reg_addr) == `EIVS_OFS_CORE_CTRL && $past(reg_wdata[`EIVS_BIT_VSEL]) == vector_base_select)
      else $error("select changed without write");
   lock_mute_a: assert property (app_lock && $past(app_lock) && $past(app_lock, 2) |-> irq_req == 7'h00)
      else $error("request from locked section");

   // Main scenarios
   cover property ($rose(vector_base_select));
   cover property ($fell(irq_blocked));
   cover property (irq_req != 7'h00);
endmodule // eivs_chk

bind eivs_top eivs_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_register_i(status_register_i),
   .exec_in_boot(exec_in_boot), .application_lock_input(application_lock_input), .irq_req(irq_req),
   .vector_base_select(vector_base_select), .irq_blocked(irq_blocked));

/* File: dv/eivs_tb.sv */
/*
 * Self-checking bench for the external interrupt and vector select block.
 * Assumes the core model and checker are compiled before it.
 */
`timescale 1ns/100ps
`include "eivs_regs.svh"

module testbench;
   logic clk_sys, rst_n, reg_wr, reg_rd, status_register_i, sleep_active, startup_done;
   logic exec_in_boot, application_lock_input, boot_lock_input, instr_done, ack_en, rd_seen;
   logic vector_base_select, irq_blocked, wake_req;
   logic [3:0] reg_addr, ack_dly;
   logic [7:0] reg_wdata, reg_rdata, lf, ack_cnt, acks0, m;
   logic [2:0] dedicated_irq_inputs;
   logic [31:0] pin_change_inputs, msk, tog;
   logic [6:0] irq_req, irq_ack;
   logic [7:0] exp_q[$];
   int n_fail, n_checks;

   // ==========================================================
   // Clock, design and partner
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   eivs_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dedicated_irq_inputs(dedicated_irq_inputs),
      .pin_change_inputs(pin_change_inputs), .status_register_i(status_register_i), .sleep_active(sleep_active),
      .startup_done(startup_done), .exec_in_boot(exec_in_boot), .application_lock_input(application_lock_input),
      .boot_lock_input(boot_lock_input), .instr_done(instr_done), .irq_ack(irq_ack), .irq_req(irq_req),
      .vector_base_select(vector_base_select), .irq_blocked(irq_blocked), .wake_req(wake_req));

   eivs_core_model core_u (.clk_sys(clk_sys), .rst_n(rst_n), .irq_req(irq_req), .irq_ack(irq_ack),
      .ack_en(ack_en), .ack_dly(ack_dly), .ack_cnt(ack_cnt));

   // ==========================================================
   // Tasks
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic test_done();
      if (exp_q.size() != 0) n_fail++;
      $display("checks=%0d failures=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Read data checked against the oldest note
   always @(posedge clk_sys) begin
      if (rd_seen && exp_q.size() > 0) cmp(reg_rdata, exp_q.pop_front());
      rd_seen <= reg_rd;
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      test_done();
   end

   // ==========================================================
   // Main sequence
   initial begin
      {rst_n, reg_wr, reg_rd, status_register_i, sleep_active, exec_in_boot, rd_seen} = 7'h00;
      {application_lock_input, boot_lock_input, instr_done} = 3'h0;
      {startup_done, ack_en} = 2'h3;
      {reg_addr, ack_dly, reg_wdata} = 16'h0000;
      dedicated_irq_inputs = 3'h7;
      pin_change_inputs = 32'hffffffff;
      lf = 8'h0c;
      n_fail = 0;
      n_checks = 0;
      cyc(12);
      rst_n <= 1'b1;
      cyc(4);
      // Reset values and unmapped offsets
      for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
      wr(`EIVS_OFS_SENSE_CTRL, 8'hff);
      rd(`EIVS_OFS_SENSE_CTRL, 8'h3f);
      // Every edge sense on every dedicated input, masked
      for (int i = 0; i < 3; i++) begin
         for (int s = 1; s < 4; s++) begin
            wr(`EIVS_OFS_SENSE_CTRL, 8'(s << (2 * i)));
            wr(`EIVS_OFS_IRQ_FLAGS, 8'h07);
            dedicated_irq_inputs[i] <= 1'b0;
            cyc(6);
            rd(`EIVS_OFS_IRQ_FLAGS, (s != 3) ? 8'(1 << i) : 8'h00);
            wr(`EIVS_OFS_IRQ_FLAGS, 8'(1 << i));
            dedicated_irq_inputs[i] <= 1'b1;
            cyc(6);
            rd(`EIVS_OFS_IRQ_FLAGS, (s != 2) ? 8'(1 << i) : 8'h00);
         end
      end
      // Low level on input 0: no flag, live request
      wr(`EIVS_OFS_SENSE_CTRL, 8'h00);
      dedicated_irq_inputs[0] <= 1'b0;
      cyc(6);
      rd(`EIVS_OFS_IRQ_FLAGS, 8'h00);
      wr(`EIVS_OFS_IRQ_MASK, 8'h01);
      cyc(4);
      cmp({1'b0, irq_req}, 8'h00);
      status_register_i <= 1'b1;
      cyc(10);
      cmp({1'b0, irq_req}, 8'h01);
      dedicated_irq_inputs[0] <= 1'b1;
      cyc(6);
      cmp({1'b0, irq_req}, 8'h00);
      // Falling edge on input 1 taken by a slow core
      wr(`EIVS_OFS_IRQ_MASK, 8'h00);
      wr(`EIVS_OFS_SENSE_CTRL, 8'h08);
      wr(`EIVS_OFS_IRQ_FLAGS, 8'h07);
      wr(`EIVS_OFS_IRQ_MASK, 8'h02);
      ack_dly <= 4'h5;
      acks0 = ack_cnt;
      dedicated_irq_inputs[1] <= 1'b0;
      cyc(16);
      cmp(ack_cnt, acks0 + 8'h01);
      rd(`EIVS_OFS_IRQ_FLAGS, 8'h00);
      dedicated_irq_inputs[1] <= 1'b1;
      // Random masks and toggles over the four groups
      status_register_i <= 1'b0;
      wr(`EIVS_OFS_PC_CTRL, 8'h0f);
      for (int r = 0; r < 4; r++) begin
         for (int g = 0; g < 4; g++) begin
            lf = lfsr(lf);
            msk[8*g +: 8] = lf;
            lf = lfsr(lf);
            tog[8*g +: 8] = lf;
            m[g] = |(msk[8*g +: 8] & tog[8*g +: 8]);
            wr(`EIVS_OFS_PC_MASK0 + 4'(g), msk[8*g +: 8]);
         end
         pin_change_inputs <= pin_change_inputs ^ tog;
         cyc(6);
         rd(`EIVS_OFS_PC_FLAGS, {4'h0, m[3:0]});
         wr(`EIVS_OFS_PC_FLAGS, 8'h0f);
         rd(`EIVS_OFS_PC_FLAGS, 8'h00);
      end
      // Vector move; request held off until the next instruction ends
      wr(`EIVS_OFS_PC_MASK0, 8'hff);
      status_register_i <= 1'b1;
      ack_dly <= 4'h0;
      acks0 = ack_cnt;
      wr(`EIVS_OFS_CORE_CTRL, 8'h01);
      wr(`EIVS_OFS_CORE_CTRL, 8'h02);
      pin_change_inputs[7:0] <= ~pin_change_inputs[7:0];
      cyc(8);
      cmp({1'b0, irq_req}, 8'h00);
      cmp({7'h00, vector_base_select}, 8'h01);
      rd(`EIVS_OFS_CORE_CTRL, 8'h02);
      instr_done <= 1'b1;
      @(posedge clk_sys);
      instr_done <= 1'b0;
      cyc(8);
      cmp(ack_cnt, acks0 + 8'h01);
      // Unlock left to lapse: late select write ignored
      wr(`EIVS_OFS_CORE_CTRL, 8'h01);
      cyc(6);
      cmp({7'h00, irq_blocked}, 8'h00);
      wr(`EIVS_OFS_CORE_CTRL, 8'h00);
      rd(`EIVS_OFS_CORE_CTRL, 8'h02);
      // Application lock with vectors in boot
      application_lock_input <= 1'b1;
      acks0 = ack_cnt;
      pin_change_inputs[7:0] <= ~pin_change_inputs[7:0];
      cyc(8);
      cmp({1'b0, irq_req}, 8'h00);
      exec_in_boot <= 1'b1;
      cyc(8);
      cmp(ack_cnt, acks0 + 8'h01);
      // Wake request in sleep from a pin change
      ack_en <= 1'b0;
      sleep_active <= 1'b1;
      pin_change_inputs[7:0] <= ~pin_change_inputs[7:0];
      cyc(8);
      cmp({7'h00, wake_req}, 8'h01);
      wr(`EIVS_OFS_PC_FLAGS, 8'h0f);
      cyc(4);
      cmp({7'h00, wake_req}, 8'h00);
      sleep_active <= 1'b0;
      // Second reset puts vectors back at program start
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      cyc(4);
      rd(`EIVS_OFS_CORE_CTRL, 8'h00);
      cyc(4);
      test_done();
   end
endmodule // testbench
